// >>> verilog/imb_pkg.sv
/*
 Shared constants and types for the ISA memory bus mapper.
 Assumes a single clock domain and an 8-bit memory interface bus.
*/
`default_nettype none
package imb_pkg;
   // Length of one memory interface cycle in clocks
   localparam int MEM_CYC = 3;
   localparam int BANK_DEV_BIT = 5;
   localparam int BANK_HI_BIT = 4;
   localparam int BANK_LO_BIT = 3;
   localparam logic [2:0] BANK_RESET = 3'h0;
   localparam logic [14:0] PTR_RESET = 15'h0000;
   localparam logic [16:0] RES_BASE = 17'h1_FC00;
   localparam logic [16:0] RES_TOP = 17'h1_FFF0;
   localparam logic [9:0] RES_LAST = 10'h03F0;
   localparam logic [15:0] PNP_ADDR_PORT = 16'h0279;
   localparam logic [15:0] PNP_WDATA_PORT = 16'h0A79;
   localparam logic [1:0] PNP_RD_LOW = 2'h3;
   localparam logic [7:0] PNP_RESET = 8'h00;
   localparam logic [7:0] IDX_WAKE = 8'h03;
   localparam logic [7:0] IDX_RES = 8'h04;
   localparam logic [7:0] IDX_STAT = 8'h05;
   localparam logic [7:0] PNP_STAT_READY = 8'h01;
   localparam int PNP_SLOTS = 19;
   localparam logic [7:0] SLOT_IDX [PNP_SLOTS] = '{
      8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
      8'h30, 8'h31, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44,
      8'h60, 8'h61, 8'h70, 8'h71};
   localparam int SLOT_RDPORT = 0;
   localparam int SLOT_ACT = 8;
   localparam int SLOT_MEM_HI = 10;
   localparam int SLOT_MEM_LO = 11;
   localparam int SLOT_IO_HI = 15;
   localparam int SLOT_IO_LO = 16;
   localparam logic [3:0] IO_BANK = 4'h1;
   localparam logic [3:0] IO_PTR_LO = 4'h2;
   localparam logic [3:0] IO_PTR_HI = 4'h3;
   localparam logic [1:0] IO_DATA_GRP = 2'h1;
   localparam logic [16:0] XCVR_BASE = 17'h0_0000;
   localparam logic [16:0] CREG_BASE = 17'h0_0020;
   localparam logic [16:0] XPER_BASE = 17'h0_0040;
   localparam logic [3:0] CMAP_OFF = 4'h0;
   localparam int ALIAS_BIT = 0;
   localparam logic [7:0] CMAP_RESET = 8'h00;
   localparam logic [7:0] AHB_BANK = 8'h00;
   localparam logic [7:0] AHB_PTR = 8'h04;
   localparam logic [7:0] AHB_STAT = 8'h08;
   localparam logic [7:0] AHB_BASE = 8'h0C;

   typedef enum logic [1:0] {KIND_MEM, KIND_DATA, KIND_RES} imb_kind_e;

   typedef struct packed {
      logic [16:0] addr;
      logic wr;
      logic [7:0] wdata;
      logic flash;
      logic sram;
      logic xper;
      logic xcvr;
      logic creg;
   } imb_mem_cmd_s;
endpackage
`default_nettype wire

// >>> verilog/imb_arbiter.sv
/*
 Round-robin owner of the memory interface bus, host side against core.
 Assumes requests stay high until granted; each cycle lasts CYC clocks.
*/
`timescale 1ns/1ns
`default_nettype none
module imb_arbiter #(
   parameter int CYC = imb_pkg::MEM_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic req_host,
   input wire logic req_core,
   output logic gnt_host,
   output logic gnt_core,
   output logic busy,
   output logic done,
   output logic owner_host
);
   logic busy_q;
   logic last_host_q;
   logic owner_q;
   logic [7:0] cnt_q;

   // Equal priority: the party not served last wins a tie
   assign gnt_host = !busy_q && req_host && (!req_core || !last_host_q);
   assign gnt_core = !busy_q && req_core && !gnt_host;
   assign busy = busy_q;
   assign done = busy_q && cnt_q == 8'h00;
   assign owner_host = owner_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         busy_q <= 1'b0;
         cnt_q <= 8'h00;
         owner_q <= 1'b0;
         last_host_q <= 1'b0;
      end else if (!busy_q) begin
         if (gnt_host || gnt_core) begin
            busy_q <= 1'b1;
            cnt_q <= 8'(CYC - 1);
            owner_q <= gnt_host;
            last_host_q <= gnt_host;
         end
      end else if (cnt_q == 8'h00) begin
         busy_q <= 1'b0;
      end else begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule
`default_nettype wire

// >>> verilog/imb_mapper.sv
/*
 ISA Plug and Play to local memory bus mapper with core sharing.
 Assumes ISA and core strobes are synchronous to CLK and held until
 the matching ready is seen high; AHB-Lite port for software.
*/
// How it works
// [RULE_01] Data port uses device bit, bank bits and 15-bit pointer
// [RULE_02] Every data-port access bumps the pointer by one
// [RULE_03] Resource reads fetch Flash from 1FC00h, stopping at 1FFF0h
// [RULE_04] Memory cycles claimed only when top 9 address bits match
// [RULE_05] Memory window base comes from config registers 40h, 41h
// [RULE_06] Host keeps the memory window on a 32K boundary
// [RULE_07] Window hit passes low bits, bank bits on top, device CE
// [RULE_08] Memory read and write strobes become bus read and write
// [RULE_09] I/O cycles compare only low 16 bits against I/O base
// [RULE_10] I/O window base comes from config registers 60h, 61h
// [RULE_11] Host keeps the I/O window on a 16-byte boundary
// [RULE_12] Address, write-data and read-data ports with 19 registers
// [RULE_13] Separate Flash, SRAM and peripheral enables, 256K reach
// [RULE_14] Extra peripheral reachable only from the core
// [RULE_15] Core registers 16 bytes, transceiver 32 bytes in core SRAM
// [RULE_16] Round-robin bus sharing, loser held in ready-wait
// [RULE_17] Upper select goes to Flash, lower to SRAM and the rest
// [RULE_18] Seventeen core address lines reach the memory bus
// [RULE_19] Alias bit maps upper 96K Flash into upper SRAM space
// [RULE_20] Transceiver and core register cycles assert no chip enable
// [RULE_21] Wide I/O bit forced to zero, 16-byte I/O window only
// [RULE_22] Pointer wraps to zero, bank and device bits untouched
`timescale 1ns/1ns
`default_nettype none
module imb_mapper (
   input wire logic CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic [23:0] ISA_SA,
   input wire logic ISA_MEMR_N,
   input wire logic ISA_MEMW_N,
   input wire logic ISA_IOR_N,
   input wire logic ISA_IOW_N,
   input wire logic [7:0] ISA_DIN,
   output logic [7:0] ISA_DOUT,
   output logic ISA_DOE,
   output logic ISA_RDY,
   input wire logic CORE_UPPER_REGION_SELECT_N,
   input wire logic CORE_LOWER_REGION_SELECT_N,
   input wire logic [16:0] CORE_ADDR,
   input wire logic CORE_RD_N,
   input wire logic CORE_WR_N,
   input wire logic [7:0] CORE_WDATA,
   output logic [7:0] CORE_RDATA,
   output logic CORE_RDY,
   output logic [16:0] MEM_ADDR,
   output logic [7:0] MEM_DOUT,
   output logic MEM_DOE,
   input wire logic [7:0] MEM_DIN,
   output logic MEM_RD_N,
   output logic MEM_WR_N,
   output logic FLASH_CHIP_ENABLE_N,
   output logic SRAM_CHIP_ENABLE_N,
   output logic EXTRA_PERIPHERAL_ENABLE_N,
   output logic TRANSCEIVER_UNIT_SEL
);
   logic isa_mr, isa_mw, isa_ir, isa_iw;
   logic [5:3] bank_q;
   logic [14:0] ptr_q;
   logic [9:0] res_ptr_q;
   logic [7:0] pnp_idx_q;
   logic [7:0] pnp_q [imb_pkg::PNP_SLOTS];
   logic [7:0] cmap_q;
   logic iow_q, host_done_q, core_done_q;
   logic [7:0] isa_dout_q, core_rdata_q;
   imb_pkg::imb_kind_e kind_q, host_kind;
   imb_pkg::imb_mem_cmd_s cmd_q, host_cmd, core_cmd;
   logic gnt_host, gnt_core, busy, done, owner_host;

   assign isa_mr = !ISA_MEMR_N;
   assign isa_mw = !ISA_MEMW_N;
   assign isa_ir = !ISA_IOR_N;
   assign isa_iw = !ISA_IOW_N;

   // Host window decode
   logic active, mem_hit, io_hit, data_port, rd_port_hit, res_rd;
   logic [15:0] io_base, rd_port;
   logic [8:0] mem_base;
   assign active = pnp_q[imb_pkg::SLOT_ACT][0];
   // see [RULE_05]
   assign mem_base = {pnp_q[imb_pkg::SLOT_MEM_HI],
                      pnp_q[imb_pkg::SLOT_MEM_LO][7]};
   // Only 9 bits compared, so the base must be 32K aligned, see [RULE_06]
   assign mem_hit = active && (isa_mr || isa_mw) &&
                    ISA_SA[23:15] == mem_base; // see [RULE_04]
   // see [RULE_10]
   assign io_base = {pnp_q[imb_pkg::SLOT_IO_HI],
                     pnp_q[imb_pkg::SLOT_IO_LO]};
   // Fixed 16-byte window; low nibble of the base ignored, see [RULE_11]
   assign io_hit = active && (isa_ir || isa_iw) &&
                   ISA_SA[15:4] == io_base[15:4]; // see [RULE_09] [RULE_21]
   assign data_port = io_hit && ISA_SA[3:2] == imb_pkg::IO_DATA_GRP;
   assign rd_port = {6'h00, pnp_q[imb_pkg::SLOT_RDPORT],
                     imb_pkg::PNP_RD_LOW};
   assign rd_port_hit = isa_ir && ISA_SA[15:0] == rd_port;
   assign res_rd = rd_port_hit && pnp_idx_q == imb_pkg::IDX_RES;

   logic host_act, host_need;
   assign host_act = mem_hit || data_port || res_rd;
   assign host_need = host_act && !host_done_q;

   // Host request to the memory bus
   always_comb begin
      host_cmd = '0;
      host_kind = imb_pkg::KIND_MEM;
      host_cmd.wdata = ISA_DIN;
      if (res_rd) begin
         host_kind = imb_pkg::KIND_RES;
         host_cmd.addr = imb_pkg::RES_BASE +
                         {7'h00, res_ptr_q}; // see [RULE_03]
         host_cmd.flash = 1'b1;
      end else begin
         if (data_port) begin
            host_kind = imb_pkg::KIND_DATA;
            host_cmd.addr = {bank_q[imb_pkg::BANK_HI_BIT:
                             imb_pkg::BANK_LO_BIT], ptr_q}; // see [RULE_01]
            host_cmd.wr = isa_iw;
         end else begin
            host_cmd.addr = {bank_q[imb_pkg::BANK_HI_BIT:
                             imb_pkg::BANK_LO_BIT],
                             ISA_SA[14:0]}; // see [RULE_07]
            host_cmd.wr = isa_mw; // see [RULE_08]
         end
         // Host never selects the extra peripheral, see [RULE_14]
         host_cmd.flash = bank_q[imb_pkg::BANK_DEV_BIT]; // see [RULE_13]
         host_cmd.sram = !bank_q[imb_pkg::BANK_DEV_BIT];
      end
   end

   // Core request decode
   logic core_upper, core_lower, core_act, core_need, lo_flash;
   assign core_upper = !CORE_UPPER_REGION_SELECT_N;
   assign core_lower = !CORE_LOWER_REGION_SELECT_N;
   assign core_act = (core_upper || core_lower) &&
                     (!CORE_RD_N || !CORE_WR_N);
   assign core_need = core_act && !core_done_q;
   assign lo_flash = core_lower && cmap_q[imb_pkg::ALIAS_BIT] &&
                     CORE_ADDR[16:15] != 2'h0; // see [RULE_19]

   always_comb begin
      core_cmd = '0;
      core_cmd.addr = CORE_ADDR; // see [RULE_18]
      core_cmd.wr = !CORE_WR_N;
      core_cmd.wdata = CORE_WDATA;
      if (core_upper || lo_flash) begin
         core_cmd.flash = 1'b1; // see [RULE_17]
      end else if (CORE_ADDR[16:5] == imb_pkg::XCVR_BASE[16:5]) begin
         core_cmd.xcvr = 1'b1; // see [RULE_15]
      end else if (CORE_ADDR[16:4] == imb_pkg::CREG_BASE[16:4]) begin
         core_cmd.creg = 1'b1; // see [RULE_15]
      end else if (CORE_ADDR[16:5] == imb_pkg::XPER_BASE[16:5]) begin
         core_cmd.xper = 1'b1; // see [RULE_14]
      end else begin
         core_cmd.sram = 1'b1; // see [RULE_17]
      end
   end

   // see [RULE_16]
   imb_arbiter #(
      .CYC(imb_pkg::MEM_CYC)
   ) u_arb (
      .clk(CLK),
      .rst(RST),
      .req_host(host_need),
      .req_core(core_need),
      .gnt_host(gnt_host),
      .gnt_core(gnt_core),
      .busy(busy),
      .done(done),
      .owner_host(owner_host)
   );

   always_ff @(posedge CLK) begin
      if (RST) begin
         cmd_q <= '0;
         kind_q <= imb_pkg::KIND_MEM;
      end else if (gnt_host) begin
         cmd_q <= host_cmd;
         kind_q <= host_kind;
      end else if (gnt_core) begin
         cmd_q <= core_cmd;
      end
   end

   // Memory interface bus drive
   assign MEM_ADDR = cmd_q.addr;
   assign MEM_DOUT = cmd_q.wdata;
   assign MEM_DOE = busy && cmd_q.wr && !cmd_q.creg;
   assign MEM_RD_N = !(busy && !cmd_q.wr);
   assign MEM_WR_N = !(busy && cmd_q.wr);
   // Internal targets leave every external enable high, see [RULE_20]
   assign FLASH_CHIP_ENABLE_N = !(busy && cmd_q.flash);
   assign SRAM_CHIP_ENABLE_N = !(busy && cmd_q.sram);
   assign EXTRA_PERIPHERAL_ENABLE_N = !(busy && cmd_q.xper);
   assign TRANSCEIVER_UNIT_SEL = busy && cmd_q.xcvr;

   logic [7:0] rd_val;
   logic host_fin, core_fin;
   assign rd_val = cmd_q.creg ?
                   (cmd_q.addr[3:0] == imb_pkg::CMAP_OFF ? cmap_q : 8'h00)
                   : MEM_DIN;
   assign host_fin = done && owner_host;
   assign core_fin = done && !owner_host;

   // Completion flags: set wins, cleared once the strobe goes away
   always_ff @(posedge CLK) begin
      if (RST) begin
         host_done_q <= 1'b0;
      end else if (host_fin) begin
         host_done_q <= 1'b1;
      end else if (!host_act) begin
         host_done_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         core_done_q <= 1'b0;
      end else if (core_fin) begin
         core_done_q <= 1'b1;
      end else if (!core_act) begin
         core_done_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         core_rdata_q <= 8'h00;
      end else if (core_fin) begin
         core_rdata_q <= rd_val;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         cmap_q <= imb_pkg::CMAP_RESET;
      end else if (core_fin && cmd_q.creg && cmd_q.wr &&
                   cmd_q.addr[3:0] == imb_pkg::CMAP_OFF) begin
         cmap_q <= cmd_q.wdata;
      end
   end

   // Host I/O register writes act on the leading edge of IOW
   logic iow_edge, pnp_wr, io_bank_wr, io_plo_wr, io_phi_wr;
   always_ff @(posedge CLK) begin
      if (RST) begin
         iow_q <= 1'b0;
      end else begin
         iow_q <= isa_iw;
      end
   end
   assign iow_edge = isa_iw && !iow_q;
   assign io_bank_wr = iow_edge && io_hit && ISA_SA[3:0] == imb_pkg::IO_BANK;
   assign io_plo_wr = iow_edge && io_hit &&
                      ISA_SA[3:0] == imb_pkg::IO_PTR_LO;
   assign io_phi_wr = iow_edge && io_hit &&
                      ISA_SA[3:0] == imb_pkg::IO_PTR_HI;
   assign pnp_wr = iow_edge && ISA_SA[15:0] == imb_pkg::PNP_WDATA_PORT;

   // AHB-Lite slave, zero wait states
   logic ahb_take, ahb_wr_q;
   logic [7:0] ahb_addr_q;
   logic [31:0] hrdata_q;
   logic ahb_bank_wr, ahb_ptr_wr;
   assign ahb_take = HSEL && HREADY && HTRANS[1];
   assign ahb_bank_wr = ahb_wr_q && ahb_addr_q == imb_pkg::AHB_BANK;
   assign ahb_ptr_wr = ahb_wr_q && ahb_addr_q == imb_pkg::AHB_PTR;

   always_ff @(posedge CLK) begin
      if (RST) begin
         ahb_wr_q <= 1'b0;
         ahb_addr_q <= 8'h00;
      end else begin
         ahb_wr_q <= ahb_take && HWRITE;
         if (ahb_take) begin
            ahb_addr_q <= HADDR[7:0];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         hrdata_q <= 32'h0000_0000;
      end else if (ahb_take && !HWRITE) begin
         case (HADDR[7:0])
            imb_pkg::AHB_BANK: hrdata_q <= {26'h000_0000, bank_q, 3'h0};
            imb_pkg::AHB_PTR: hrdata_q <= {17'h0_0000, ptr_q};
            imb_pkg::AHB_STAT: hrdata_q <= {11'h000, cmap_q, res_ptr_q,
                                            busy, owner_host, host_need};
            imb_pkg::AHB_BASE: hrdata_q <= {io_base,
                                            pnp_q[imb_pkg::SLOT_MEM_HI],
                                            pnp_q[imb_pkg::SLOT_MEM_LO]};
            default: hrdata_q <= 32'h0000_0000;
         endcase
      end
   end
   assign HRDATA = hrdata_q;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   // Bank and device select; wide I/O bit is never stored, see [RULE_21]
   always_ff @(posedge CLK) begin
      if (RST) begin
         bank_q <= imb_pkg::BANK_RESET;
      end else if (io_bank_wr) begin
         bank_q <= ISA_DIN[5:3];
      end else if (ahb_bank_wr) begin
         bank_q <= HWDATA[5:3];
      end
   end

   logic ptr_inc;
   assign ptr_inc = host_fin && kind_q == imb_pkg::KIND_DATA;
   always_ff @(posedge CLK) begin
      if (RST) begin
         ptr_q <= imb_pkg::PTR_RESET;
      end else if (io_plo_wr) begin
         ptr_q[7:0] <= ISA_DIN;
      end else if (io_phi_wr) begin
         ptr_q[14:8] <= ISA_DIN[6:0];
      end else if (ahb_ptr_wr) begin
         ptr_q <= HWDATA[14:0];
      end else if (ptr_inc) begin
         ptr_q <= ptr_q + 15'h0001; // see [RULE_02] [RULE_22]
      end
   end

   // Plug and Play configuration ports, see [RULE_12]
   always_ff @(posedge CLK) begin
      if (RST) begin
         pnp_idx_q <= 8'h00;
      end else if (iow_edge && ISA_SA[15:0] == imb_pkg::PNP_ADDR_PORT) begin
         pnp_idx_q <= ISA_DIN;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         res_ptr_q <= 10'h000;
      end else if (pnp_wr && pnp_idx_q == imb_pkg::IDX_WAKE) begin
         res_ptr_q <= 10'h000;
      end else if (host_fin && kind_q == imb_pkg::KIND_RES &&
                   res_ptr_q != imb_pkg::RES_LAST) begin
         res_ptr_q <= res_ptr_q + 10'h001; // see [RULE_03]
      end
   end

   generate
      for (genvar g = 0; g < imb_pkg::PNP_SLOTS; g++) begin : g_pnp
         logic [7:0] val_q;
         always_ff @(posedge CLK) begin
            if (RST) begin
               val_q <= imb_pkg::PNP_RESET;
            end else if (pnp_wr && pnp_idx_q == imb_pkg::SLOT_IDX[g] &&
                         pnp_idx_q != imb_pkg::IDX_RES &&
                         pnp_idx_q != imb_pkg::IDX_STAT) begin
               val_q <= ISA_DIN; // see [RULE_12]
            end
         end
         assign pnp_q[g] = val_q;
      end
   endgenerate

   // Host read data
   logic [7:0] pnp_rd, io_rd_val;
   always_comb begin
      pnp_rd = 8'h00;
      for (int s = 0; s < imb_pkg::PNP_SLOTS; s++) begin
         if (pnp_idx_q == imb_pkg::SLOT_IDX[s]) begin
            pnp_rd = pnp_q[s];
         end
      end
      if (pnp_idx_q == imb_pkg::IDX_STAT) begin
         pnp_rd = imb_pkg::PNP_STAT_READY;
      end
   end

   always_comb begin
      case (ISA_SA[3:0])
         imb_pkg::IO_BANK: io_rd_val = {2'h0, bank_q, 3'h0};
         imb_pkg::IO_PTR_LO: io_rd_val = ptr_q[7:0];
         imb_pkg::IO_PTR_HI: io_rd_val = {1'b0, ptr_q[14:8]};
         default: io_rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         isa_dout_q <= 8'h00;
      end else if (host_fin) begin
         isa_dout_q <= rd_val;
      end else if (io_hit && !data_port) begin
         isa_dout_q <= io_rd_val;
      end else if (rd_port_hit && !res_rd) begin
         isa_dout_q <= pnp_rd;
      end
   end

   assign ISA_DOUT = isa_dout_q;
   assign ISA_DOE = (isa_mr && mem_hit) || (isa_ir && io_hit) || rd_port_hit;
   assign ISA_RDY = !host_need; // see [RULE_16]
   assign CORE_RDATA = core_rdata_q;
   assign CORE_RDY = !core_need; // see [RULE_16]

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_core_done_host_wait;
      core_fin && host_need;
   endsequence
   sequence s_host_mem_grant;
      gnt_host && mem_hit;
   endsequence

   a_ptr_step: assert property ( // see [RULE_02]
      ptr_inc && !io_plo_wr && !io_phi_wr && !ahb_ptr_wr
      |=> ptr_q == $past(ptr_q) + 15'h0001)
      else $error("pointer did not step by one");
   a_win_addr: assert property ( // see [RULE_07]
      s_host_mem_grant |=> MEM_ADDR[14:0] == ISA_SA[14:0] &&
      FLASH_CHIP_ENABLE_N == !bank_q[imb_pkg::BANK_DEV_BIT])
      else $error("window address or enable wrong");
   a_strobe_map: assert property ( // see [RULE_08]
      s_host_mem_grant |=>
      (MEM_WR_N == ISA_MEMW_N && MEM_RD_N == ISA_MEMR_N)[*3])
      else $error("bus strobes do not follow host strobes");
   a_res_range: assert property ( // see [RULE_03]
      busy && owner_host && kind_q == imb_pkg::KIND_RES
      |-> cmd_q.flash && cmd_q.addr >= imb_pkg::RES_BASE &&
      cmd_q.addr <= imb_pkg::RES_TOP)
      else $error("resource read outside its range");
   a_no_ext_ce: assert property ( // see [RULE_20]
      busy && (cmd_q.xcvr || cmd_q.creg) |-> FLASH_CHIP_ENABLE_N &&
      SRAM_CHIP_ENABLE_N && EXTRA_PERIPHERAL_ENABLE_N)
      else $error("chip enable on internal cycle");
   a_host_no_xper: assert property ( // see [RULE_14]
      busy && owner_host |-> EXTRA_PERIPHERAL_ENABLE_N)
      else $error("host reached the extra peripheral");
   a_rr_turn: assert property ( // see [RULE_16]
      s_core_done_host_wait |=> gnt_host ##1 busy && owner_host)
      else $error("waiting host not granted next");
   a_core_flash: assert property ( // see [RULE_18]
      gnt_core && core_upper |=> !FLASH_CHIP_ENABLE_N &&
      MEM_ADDR == $past(CORE_ADDR))
      else $error("upper select not routed to flash");
   a_alias_map: assert property ( // see [RULE_19]
      gnt_core && lo_flash |=> !FLASH_CHIP_ENABLE_N && SRAM_CHIP_ENABLE_N)
      else $error("aliased region not sent to flash");
   a_host_wait: assert property ( // see [RULE_16]
      host_need && busy && !owner_host |-> !ISA_RDY && !gnt_host)
      else $error("host not held while core owns bus");
endmodule
`default_nettype wire

// >>> tb/imb_mem_model.sv
/*
 Behavioural Flash, SRAM and extra peripheral on the memory bus.
 Assumes active-low enables and read strobe driven by the mapper.
*/
`timescale 1ns/1ns
`default_nettype none
module imb_mem_model (
   input wire logic [16:0] a,
   input wire logic rd_n,
   input wire logic f_n,
   input wire logic s_n,
   input wire logic x_n,
   output logic [7:0] q
);
   initial q = 8'h00;
   // Each device answers only under its own enable; else the bus flips
   always @(a, rd_n, f_n, s_n, x_n) begin
      if (!rd_n && !(f_n && s_n && x_n)) begin
         q = a[7:0] ^ (!f_n ? 8'hA5 : 8'h3C);
      end else begin
         q = ~q;
      end
   end
endmodule
`default_nettype wire

// >>> tb/isa_memory_bus_mapper_tb.sv
/*
 Self-checking bench for the ISA memory bus mapper.
 Assumes the memory model on the far side and AHB-Lite software access.
*/
`timescale 1ns/1ns
`default_nettype none
module isa_memory_bus_mapper_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   logic [1:0] htrans = 2'h0, csn = 2'h3, crw = 2'h3;
   logic hwrite = 1'b0, hro, hresp, doe, rdy, crdy, mdoe, e;
   logic mrd_n, mwr_n, fce_n, sce_n, xce_n, tsel;
   logic [23:0] sa = 24'h0;
   logic [3:0] isn = 4'hF, mon_ce_q;
   logic [7:0] din = 8'h0, cwd = 8'h0, dout, crdata, mdo, mdi, d;
   logic [16:0] ca = 17'h0, ma, mon_a_q;
   logic [8:0] mon_d_q;
   logic [16:0] ctab [4] = '{17'h1_2345, 17'h0_8000, 17'h0_0045, 17'h0_0003};
   logic [3:0] cce [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
   int fail_count = 0;
   int tests_run = 0;
   int mcnt = 0;
   int n;

   always #25 clk = ~clk;

   imb_mapper u_dut (.CLK(clk), .RST(rst), .HSEL(1'b1), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hro), .HRDATA(hrdata), .HREADYOUT(hro), .HRESP(hresp),
      .ISA_SA(sa), .ISA_MEMR_N(isn[0]), .ISA_MEMW_N(isn[1]),
      .ISA_IOR_N(isn[2]), .ISA_IOW_N(isn[3]), .ISA_DIN(din),
      .ISA_DOUT(dout), .ISA_DOE(doe), .ISA_RDY(rdy),
      .CORE_UPPER_REGION_SELECT_N(csn[0]),
      .CORE_LOWER_REGION_SELECT_N(csn[1]), .CORE_ADDR(ca),
      .CORE_RD_N(crw[0]), .CORE_WR_N(crw[1]), .CORE_WDATA(cwd),
      .CORE_RDATA(crdata), .CORE_RDY(crdy), .MEM_ADDR(ma), .MEM_DOUT(mdo),
      .MEM_DOE(mdoe), .MEM_DIN(mdi), .MEM_RD_N(mrd_n), .MEM_WR_N(mwr_n),
      .FLASH_CHIP_ENABLE_N(fce_n), .SRAM_CHIP_ENABLE_N(sce_n),
      .EXTRA_PERIPHERAL_ENABLE_N(xce_n), .TRANSCEIVER_UNIT_SEL(tsel));
   imb_mem_model u_mem (.a(ma), .rd_n(mrd_n), .f_n(fce_n), .s_n(sce_n),
      .x_n(xce_n), .q(mdi));

   // Remembers address and selects of the last memory bus strobe
   always @(posedge clk) begin
      if (!mrd_n || !mwr_n) begin
         mcnt <= mcnt + 1;
         mon_a_q <= ma;
         mon_ce_q <= {~fce_n, ~sce_n, ~xce_n, tsel};
         mon_d_q <= {mdoe, mdo};
      end
   end

   function automatic logic [7:0] pat(input logic [16:0] a, input logic f);
      return a[7:0] ^ (f ? 8'hA5 : 8'h3C);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
      input string nm);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
      @(posedge clk);
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clk);
      while (!hro) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (!hro) @(posedge clk);
      r = hrdata;
   endtask

   // Kind: 0 memory read, 1 memory write, 2 I/O read, 3 I/O write
   task automatic isa(input int k, input logic [23:0] a,
      input logic [7:0] wd);
      @(posedge clk);
      sa <= a;
      din <= wd;
      isn <= ~(4'h1 << k);
      repeat (2) @(posedge clk);
      while (!rdy) @(posedge clk);
      d = dout;
      e = doe;
      isn <= 4'hF;
   endtask

   task automatic pnp(input logic [7:0] idx, input logic [7:0] v);
      isa(3, 24'h00_0279, idx);
      isa(3, 24'h00_0A79, v);
   endtask

   task automatic core(input logic up, input logic [16:0] a, input int k,
      input logic [7:0] wd);
      @(posedge clk);
      ca <= a;
      cwd <= wd;
      csn <= up ? 2'h2 : 2'h1;
      crw <= ~(2'h1 << k);
      repeat (2) @(posedge clk);
      while (!crdy) @(posedge clk);
      csn <= 2'h3;
      crw <= 2'h3;
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #(4000 * 50);
      fail_count++;
      tally_and_finish;
   end

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      pnp(8'h30, 8'h01);
      pnp(8'h40, 8'h0D);
      pnp(8'h41, 8'h80);
      pnp(8'h60, 8'h03);
      pnp(8'h61, 8'h00);
      pnp(8'h00, 8'h80);
      ahb(1'b0, imb_pkg::AHB_BASE, 32'h0);
      chk(r, 32'h0300_0D80, "bases");
      chk(hresp, 1'b0, "response");
      ahb(1'b1, imb_pkg::AHB_BANK, 32'h0000_002C);
      ahb(1'b1, imb_pkg::AHB_PTR, 32'h0000_7FFF);
      ahb(1'b0, imb_pkg::AHB_BANK, 32'h0);
      chk(r, 32'h0000_0028, "bank");
      isa(2, 24'hAB_0304, 8'h00);
      chk(mon_a_q, 17'h0_FFFF, "data port addr");
      chk(mon_ce_q, 4'h8, "data port ce");
      chk(d, pat(17'h0_FFFF, 1'b1), "data port read");
      ahb(1'b0, imb_pkg::AHB_PTR, 32'h0);
      chk(r, 32'h0, "pointer wrap");
      ahb(1'b0, imb_pkg::AHB_BANK, 32'h0);
      chk(r, 32'h0000_0028, "bank kept");
      isa(0, 24'h0D_8123, 8'h00);
      chk(mon_a_q, 17'h0_8123, "window addr");
      chk(mon_ce_q, 4'h8, "window ce");
      chk(d, pat(17'h0_8123, 1'b1), "window read");
      chk(e, 1'b1, "window drive");
      isa(3, 24'h00_0301, 8'h14);
      isa(2, 24'h00_0301, 8'h00);
      chk(d, 8'h10, "bank port");
      isa(1, 24'h0D_FFFF, 8'h66);
      chk(mon_a_q, 17'h1_7FFF, "sram addr");
      chk(mon_ce_q, 4'h4, "sram ce");
      chk(mon_d_q, 9'h166, "sram write data");
      n = mcnt;
      isa(0, 24'h0D_0000, 8'h00);
      chk(mcnt, n, "window miss");
      chk(e, 1'b0, "miss drive");
      pnp(8'h03, 8'h00);
      isa(3, 24'h00_0279, imb_pkg::IDX_RES);
      for (int i = 0; i < 2; i++) begin
         isa(2, 24'h00_0203, 8'h00);
         chk(mon_a_q, 17'h1_FC00 + i, "resource addr");
         chk(mon_ce_q, 4'h8, "resource ce");
      end
      for (int i = 0; i < 4; i++) begin
         core(i == 0, ctab[i], 0, 8'h00);
         chk(mon_a_q, ctab[i], "core addr");
         chk(mon_ce_q, cce[i], "core ce");
      end
      core(1'b0, imb_pkg::CREG_BASE, 1, 8'h01);
      core(1'b0, imb_pkg::CREG_BASE, 0, 8'h00);
      chk(crdata, 8'h01, "core map read");
      core(1'b0, 17'h0_9000, 0, 8'h00);
      chk(mon_ce_q, 4'h8, "alias flash");
      core(1'b0, 17'h0_1000, 0, 8'h00);
      chk(mon_ce_q, 4'h4, "alias low sram");
      ahb(1'b0, imb_pkg::AHB_STAT, 32'h0);
      chk(r, 32'h0000_2010, "status");
      n = mcnt;
      // Core asks one cycle first, so the host must wait for its turn
      fork
         begin
            @(posedge clk);
            isa(0, 24'h0D_8001, 8'h00);
         end
         core(1'b1, 17'h1_0000, 0, 8'h00);
      join
      chk(mcnt - n, 2 * imb_pkg::MEM_CYC, "shared cycles");
      chk(d, pat(17'h1_0001, 1'b0), "held host read");
      tally_and_finish;
   end
endmodule
`default_nettype wire
